// ==== rtl/overrange_flag_sysref_align.sv ====
// Over-range flag generation, shared pin drive and SYSREF to multiframe alignment
`timescale 1ns/1ps
module overrange_flag_sysref_align
  import ovr_sysref_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire ovr_sysref_pkg::div_code_t clock_divide_ratio,
  input wire logic sample_over_range,
  input wire ovr_sysref_pkg::extra_frames_t deassert_extra_frames,
  input wire logic ovr_output_mode,
  input wire logic spi_read_active,
  input wire logic spi_read_data,
  input wire logic sysref,
  output logic frame_enable,
  output logic overrange_flag,
  output logic serial_out_overrange_pin_o,
  output logic serial_out_overrange_pin_oe,
  output logic lmfc_boundary,
  output logic lmfc_aligned,
  output logic sysref_width_error
);

  // =====================================================================
  // Frame clock divider
  logic [1:0] div_cnt_q;
  logic [1:0] div_cnt_d;
  logic frame_en_q;
  logic [1:0] div_last;
  logic frame_tick;

  assign div_last = (clock_divide_ratio == DIV_BY_2) ? DIV2_LAST :
                    (clock_divide_ratio == DIV_BY_4) ? DIV4_LAST : DIV1_LAST;
  // A ratio change mid-count may leave the counter above the new limit; wrap it
  assign frame_tick = (div_cnt_q >= div_last);
  assign div_cnt_d = frame_tick ? 2'h0 : div_cnt_q + 2'h1;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= 2'h0;
      frame_en_q <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      frame_en_q <= frame_tick;
    end
  end

  assign frame_enable = frame_en_q;

  // =====================================================================
  // Over-range pipeline and flag
  logic ovr_delayed;

  frame_delay_line #(
    .DEPTH(OVR_ASSERT_FRAMES)
  ) u_ovr_delay (
    .mclk(mclk),
    .rst_n(rst_n),
    .shift_en(frame_en_q),
    .din(sample_over_range),
    .dout(ovr_delayed)
  );

  logic flag_q;
  logic flag_d;
  logic [3:0] hold_q;
  logic [3:0] hold_d;
  logic hold_done;

  assign hold_done = (hold_q == 4'h0);

  always_comb begin
    flag_d = flag_q;
    hold_d = hold_q;
    if (frame_en_q) begin
      if (ovr_delayed) begin
        flag_d = 1'b1;
        // Every further out-of-range sample restarts the drop delay
        hold_d = (deassert_extra_frames > OVR_EXTRA_MAX) ? OVR_EXTRA_MAX : deassert_extra_frames;
      end else if (flag_q) begin
        if (hold_done) begin
          flag_d = 1'b0;
        end else begin
          hold_d = hold_q - 4'h1;
        end
      end
    end
  end

  // =====================================================================
  // Shared pin: serial read data wins, else flag in overrange mode
  logic pin_d;
  logic pin_oe_d;
  logic pin_q;
  logic pin_oe_q;

  assign pin_d = spi_read_active ? spi_read_data : (ovr_output_mode & flag_d);
  assign pin_oe_d = spi_read_active | ovr_output_mode;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      hold_q <= 4'h0;
      pin_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      hold_q <= hold_d;
      pin_q <= pin_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign overrange_flag = flag_q;
  assign serial_out_overrange_pin_o = pin_q;
  assign serial_out_overrange_pin_oe = pin_oe_q;

  // =====================================================================
  // SYSREF edge capture and pulse width watch
  logic sysref_q;
  logic sysref_rise;
  logic sysref_edge;
  logic [1:0] level_frames_q;
  logic [1:0] level_frames_d;
  logic width_err_q;
  logic width_short;

  assign sysref_rise = sysref & ~sysref_q;
  assign sysref_edge = sysref ^ sysref_q;
  // An edge that ends a level held for fewer than two frames sets the width error
  assign width_short = sysref_edge & (level_frames_q < SYSREF_MIN_FRAMES);
  // The edge cycle already holds the new level, so it counts when it is a frame
  assign level_frames_d = sysref_edge ? {1'b0, frame_en_q} :
                          (frame_en_q && level_frames_q < SYSREF_MIN_FRAMES) ? level_frames_q + 2'h1 :
                          level_frames_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sysref_q <= 1'b0;
      // Start saturated so the very first edge is not flagged
      level_frames_q <= SYSREF_MIN_FRAMES;
      width_err_q <= 1'b0;
    end else begin
      sysref_q <= sysref;
      level_frames_q <= level_frames_d;
      width_err_q <= width_err_q | width_short;
    end
  end

  assign sysref_width_error = width_err_q;

  // =====================================================================
  // Multiframe boundary alignment
  align_state_t state_q;
  align_state_t state_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic boundary_q;
  logic boundary_d;
  logic aligned_q;
  logic [4:0] lmfc_delay;
  logic [7:0] lmfc_load;
  logic [7:0] period_load;
  logic cnt_zero;

  assign lmfc_delay = (clock_divide_ratio == DIV_BY_2) ? LMFC_DELAY_DIV2 :
                      (clock_divide_ratio == DIV_BY_4) ? LMFC_DELAY_DIV4 : LMFC_DELAY_DIV1;
  assign lmfc_load = {3'h0, lmfc_delay} - 8'h01;
  assign period_load = (clock_divide_ratio == DIV_BY_2) ? {1'b0, MULTIFRAME_FRAMES, 1'b0} - 8'h01 :
                       (clock_divide_ratio == DIV_BY_4) ? {MULTIFRAME_FRAMES, 2'h0} - 8'h01 :
                       {2'h0, MULTIFRAME_FRAMES} - 8'h01;
  assign cnt_zero = (cnt_q == 8'h00);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    boundary_d = 1'b0;
    case (state_q)
      ALIGN_IDLE: begin
        if (sysref_rise) begin
          state_d = ALIGN_WAIT;
          cnt_d = lmfc_load;
        end
      end
      ALIGN_WAIT, ALIGN_RUN: begin
        if (sysref_rise) begin
          // A new SYSREF realigns the boundary from scratch
          state_d = ALIGN_WAIT;
          cnt_d = lmfc_load;
        end else if (cnt_zero) begin
          state_d = ALIGN_RUN;
          boundary_d = 1'b1;
          cnt_d = period_load;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: begin
        state_d = ALIGN_IDLE;
        cnt_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ALIGN_IDLE;
      cnt_q <= 8'h00;
      boundary_q <= 1'b0;
      aligned_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      boundary_q <= boundary_d;
      // Registered copy of the run state keeps the output glitch free
      aligned_q <= (state_d == ALIGN_RUN);
    end
  end

  assign lmfc_boundary = boundary_q;
  assign lmfc_aligned = aligned_q;

endmodule

// ==== pkg/ovr_sysref_pkg.sv ====
// Shared constants and types for the over-range flag and SYSREF alignment block
package ovr_sysref_pkg;

  typedef logic [1:0] div_code_t;
  typedef logic [3:0] extra_frames_t;

  // =====================================================================
  // Divider codes
  localparam div_code_t DIV_BY_1 = 2'h0;
  localparam div_code_t DIV_BY_2 = 2'h1;
  localparam div_code_t DIV_BY_4 = 2'h2;
  localparam logic [1:0] DIV2_LAST = 2'h1;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [1:0] DIV1_LAST = 2'h0;

  // =====================================================================
  // Over-range timing, in frame clock cycles
  localparam int OVR_ASSERT_FRAMES = 8;
  localparam extra_frames_t OVR_EXTRA_MAX = 4'hF;

  // =====================================================================
  // SYSREF timing
  localparam logic [1:0] SYSREF_MIN_FRAMES = 2'h2;
  localparam logic [4:0] LMFC_DELAY_DIV1 = 5'h04;
  localparam logic [4:0] LMFC_DELAY_DIV2 = 5'h0A;
  localparam logic [4:0] LMFC_DELAY_DIV4 = 5'h12;
  // Frames per multiframe after alignment
  localparam logic [5:0] MULTIFRAME_FRAMES = 6'h20;

  typedef enum logic [1:0] {
    ALIGN_IDLE,
    ALIGN_WAIT,
    ALIGN_RUN
  } align_state_t;

endpackage

// ==== rtl/frame_delay_line.sv ====
// Enable-gated shift register used as a fixed frame delay
`timescale 1ns/1ps
module frame_delay_line #(
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic shift_en,
  input wire logic din,
  output logic dout
);

  logic [DEPTH-1:0] stage_q;
  logic [DEPTH-1:0] stage_d;

  generate
    if (DEPTH == 1) begin : g_one
      assign stage_d = din;
    end else begin : g_many
      assign stage_d = {stage_q[DEPTH-2:0], din};
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= '0;
    end else if (shift_en) begin
      stage_q <= stage_d;
    end
  end

  assign dout = stage_q[DEPTH-1];

endmodule

// ==== tb/ovr_sysref_asserts.sv ====
// Assertion checker for the over-range flag and SYSREF alignment block
`timescale 1ns/1ps
module ovr_sysref_asserts
  import ovr_sysref_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire ovr_sysref_pkg::div_code_t clock_divide_ratio,
  input wire logic sample_over_range,
  input wire logic ovr_output_mode,
  input wire logic spi_read_active,
  input wire logic sysref,
  input wire logic frame_enable,
  input wire logic overrange_flag,
  input wire logic serial_out_overrange_pin_o,
  input wire logic serial_out_overrange_pin_oe,
  input wire logic lmfc_boundary
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Only divide-by-1 gives fixed cycle counts for the flag checks
  wire div1 = clock_divide_ratio == DIV_BY_1;
  // ====================================
  // Sequences
  sequence s_over_taken;
    sample_over_range && frame_enable && div1;
  endsequence
  sequence s_sysref_edge(div_code_t d);
    $rose(sysref) && clock_divide_ratio == d;
  endsequence
  // ====================================
  // Properties
  a_flag_rise_delay: assert property (s_over_taken |-> ##9 overrange_flag) else $error("flag rise late");
  a_flag_fall_inrange: assert property (div1 && $fell(overrange_flag) |-> $past(!sample_over_range, 9))
    else $error("flag fell early");
  a_flag_hold_run: assert property (s_over_taken ##1 s_over_taken |-> ##8 overrange_flag [*2])
    else $error("flag dropped in run");
  a_lmfc_div_one: assert property (s_sysref_edge(DIV_BY_1) |-> ##5 lmfc_boundary) else $error("boundary /1");
  a_lmfc_div_two: assert property (s_sysref_edge(DIV_BY_2) |-> ##11 lmfc_boundary) else $error("boundary /2");
  a_lmfc_div_four: assert property (s_sysref_edge(DIV_BY_4) |-> ##19 lmfc_boundary) else $error("boundary /4");
  a_pin_ovr_mode: assert property (ovr_output_mode && !spi_read_active |=> serial_out_overrange_pin_oe
    && serial_out_overrange_pin_o == overrange_flag) else $error("pin not flag");
  a_pin_hiz_idle: assert property (!ovr_output_mode && !spi_read_active |=> !serial_out_overrange_pin_oe)
    else $error("pin driven");
  a_frame_div_two: assert property (frame_enable && clock_divide_ratio == DIV_BY_2 |=> !frame_enable
    ##1 frame_enable) else $error("frame rate /2");
endmodule

// ==== tb/sysref_source.sv ====
// Clock source model driving SYSREF in frame-aligned pulses
`timescale 1ns/1ps
module sysref_source (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic frame_enable,
  input wire logic fire,
  input wire logic [3:0] high_frames,
  output logic sysref
);
  logic [3:0] cnt_q;
  wire rise = !sysref && fire && cnt_q >= 4'h2;
  // A high_frames below 2 breaks the width on purpose
  wire fall = sysref && cnt_q + 4'h1 >= high_frames;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sysref <= 1'b0;
      cnt_q <= 4'h0;
    end else if (frame_enable) begin
      sysref <= sysref ^ (rise | fall);
      cnt_q <= (rise | fall) ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hF};
    end
  end
endmodule

// ==== tb/overrange_flag_sysref_align_test.sv ====
// Self-checking bench for the over-range flag and SYSREF alignment block
`timescale 1ns/1ps
module overrange_flag_sysref_align_test;
  import ovr_sysref_pkg::*;
  typedef struct {div_code_t r; extra_frames_t e; int n; int d; int lm;} row_t;
  row_t rows[5] = '{'{DIV_BY_1, 4'h0, 1, 1, 4}, '{DIV_BY_1, 4'hF, 2, 1, 4}, '{DIV_BY_2, 4'h3, 2, 2, 10},
                    '{DIV_BY_4, 4'h1, 1, 4, 18}, '{2'h3, 4'h2, 3, 1, 4}};
  logic mclk = 0, rst_n = 0, over = 0, mode = 0, rd = 0, rdd = 0, fire = 0;
  div_code_t ratio = DIV_BY_1;
  extra_frames_t extra = 4'h0;
  logic [3:0] hi = 4'h3;
  logic fe, flag, pin, oe, lmfc, algn, werr, sref;
  int cyc = 0, error_cnt = 0, check_count = 0, t0, t1, t2;
  always #5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  overrange_flag_sysref_align i_overrange_flag_sysref_align (.mclk(mclk), .rst_n(rst_n), .clock_divide_ratio(ratio),
    .sample_over_range(over), .deassert_extra_frames(extra), .ovr_output_mode(mode), .spi_read_active(rd),
    .spi_read_data(rdd), .sysref(sref), .frame_enable(fe), .overrange_flag(flag), .serial_out_overrange_pin_o(pin),
    .serial_out_overrange_pin_oe(oe), .lmfc_boundary(lmfc), .lmfc_aligned(algn), .sysref_width_error(werr));
  sysref_source i_sysref_source (.mclk(mclk), .rst_n(rst_n), .frame_enable(fe), .fire(fire), .high_frames(hi),
    .sysref(sref));
  // ====================================
  // Tasks
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic chk_num(input string nm, input int exp, input int got);
    check_count++;
    if (got != exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  // Inputs move 1 ns after the edge, clear of the sampling edge
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? flag : s == 1 ? lmfc : s == 2 ? fe : sref;
  endfunction
  task automatic wait_for(input int s, input logic v, output int t);
    int k = 0;
    while (pick(s) !== v) begin
      tick(1);
      k++;
      if (k > 600) begin
        error_cnt++;
        $display("MISMATCH wait %0d expected %b seen timeout", s, v);
        end_of_test();
      end
    end
    t = cyc;
  endtask
  // ====================================
  // Main sequence
  initial begin
    for (int i = 0; i < 5; i++) begin
      rst_n = 0;
      ratio = rows[i].r;
      tick(16);
      rst_n = 1;
      tick(1);
      extra = rows[i].e;
      mode = 1;
      wait_for(2, 1, t0);
      over = 1;
      tick(1);
      t0 = cyc;
      tick(rows[i].n * rows[i].d - 1);
      over = 0;
      wait_for(0, 1, t1);
      chk_num("rise delay", 8 * rows[i].d, t1 - t0);
      chk_bit("pin flag", 1'b1, pin & oe);
      wait_for(0, 0, t2);
      chk_num("high time", (rows[i].n + rows[i].e) * rows[i].d, t2 - t1);
      fire = 1;
      wait_for(3, 1, t0);
      fire = 0;
      wait_for(1, 1, t1);
      chk_num("lmfc delay", rows[i].lm + 1, t1 - t0);
      chk_bit("aligned", 1'b1, algn);
      chk_bit("width ok", 1'b0, werr);
    end
    rd = 1;
    rdd = 1;
    tick(2);
    chk_bit("read wins", 1'b1, pin & oe);
    mode = 0;
    tick(2);
    chk_bit("pin read", 1'b1, pin & oe);
    rd = 0;
    tick(2);
    chk_bit("pin idle", 1'b0, oe);
    hi = 4'h1;
    fire = 1;
    wait_for(3, 1, t0);
    fire = 0;
    tick(8);
    chk_bit("width error", 1'b1, werr);
    end_of_test();
  end
endmodule
bind overrange_flag_sysref_align ovr_sysref_asserts i_ovr_sysref_asserts (.mclk(mclk), .rst_n(rst_n),
  .clock_divide_ratio(clock_divide_ratio), .sample_over_range(sample_over_range), .ovr_output_mode(ovr_output_mode),
  .spi_read_active(spi_read_active), .sysref(sysref), .frame_enable(frame_enable), .overrange_flag(overrange_flag),
  .serial_out_overrange_pin_o(serial_out_overrange_pin_o), .serial_out_overrange_pin_oe(serial_out_overrange_pin_oe),
  .lmfc_boundary(lmfc_boundary));
